// *** hw/eeprom_device.sv ***
// serial eeprom device end: command decode, array, lock, self-timed cycles
// assumes all pins come from another party and are resynchronised here
// Functional notes
// - instruction is 11 bits x16, 12 bits x8
// - serial input sampled on serial clock rise
// - output released except read data or status
// - status drives low busy, high ready
// - clocked one during status releases output
// - start bit, opcode, address, optional data
// - 10 read, 11 erase, 01 write
// - opcode 00 decoded by top address bits
// - read sends a zero, then word msb first
// - read bits change on clock rise
// - sequential read advances address, wraps to zero
// - leading zero only before first burst word
// - programming locked after reset until unlocked
// - lock state persists until reset or relock
// - reads work whether locked or not
// - select falling starts self-timed word write
// - program cycle needs no serial clock
// - word write stores data outright, no prior clear
// - word erase leaves all ones
// - clear-all leaves whole array ones
// - fill-all stores data into every word
// - width select chooses 16 or 8 bit words
`timescale 1ns/1ps
module eeprom_device
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC
) (
  input  wire logic clk,
  input  wire logic reset,
  eeprom_if.dev     pins,
  output logic      prog_busy,
  output logic      prog_unlocked
);

  localparam int TW = $clog2(PROG_CYCLES + 1);

  typedef enum logic [2:0] {
    S_IDLE, S_OP, S_ADDR, S_DATA, S_READ, S_DONE, S_BUSY
  } dev_state_t;

  typedef struct packed {
    logic [2:0]  cs_s;
    logic [2:0]  sck_s;
    logic [2:0]  sdi_s;
    logic [2:0]  wws_s;
    logic        cs_f;
    logic        sck_f;
    logic        sdi_f;
    logic        wide_f;
    dev_state_t  st;
    logic [4:0]  cnt;
    logic [1:0]  op;
    logic [8:0]  addr;
    logic [15:0] data;
    logic [15:0] sh;
    logic        unlock;
    logic        pend;
    logic        ran;
    logic        stat;
    logic        out;
    logic        drive;
    logic [TW-1:0] timer;
    logic [8:0]  sweep;
  } dev_t;

  dev_t        s_r;
  dev_t        s_nxt;
  logic [15:0] mem [WORDS];
  logic        we;
  logic [7:0]  waddr;
  logic [15:0] wdata;
  logic [7:0]  widx;
  logic [15:0] rd;
  logic [15:0] val;
  logic [4:0]  al;
  logic [4:0]  dl;
  logic        rise;
  logic        cs_fall;
  logic        cs_rise;

  function automatic logic [1:0] ext_code(input logic [8:0] a, input logic wide);
    return wide ? a[7:6] : a[8:7];
  endfunction : ext_code

  always_comb begin
    s_nxt = s_r;
    we    = 1'b0;
    waddr = 8'h00;
    wdata = 16'h0000;
    al    = addr_len(s_r.wide_f);
    dl    = data_len(s_r.wide_f);
    widx  = s_r.wide_f ? s_r.addr[7:0] : s_r.addr[8:1];
    rd    = mem[widx];
    val   = 16'h0000;
    // three-stage resync; a level counts once stages two and three agree
    s_nxt.cs_s  = {s_r.cs_s[1:0], pins.cs};
    s_nxt.sck_s = {s_r.sck_s[1:0], pins.sck};
    s_nxt.sdi_s = {s_r.sdi_s[1:0], pins.sdi};
    s_nxt.wws_s = {s_r.wws_s[1:0], pins.wws};
    if (s_r.cs_s[1] == s_r.cs_s[2]) s_nxt.cs_f = s_r.cs_s[2];
    if (s_r.sck_s[1] == s_r.sck_s[2]) s_nxt.sck_f = s_r.sck_s[2];
    if (s_r.sdi_s[1] == s_r.sdi_s[2]) s_nxt.sdi_f = s_r.sdi_s[2];
    // width only follows the strap between instructions
    if (s_r.wws_s[1] == s_r.wws_s[2] && s_r.st == S_IDLE) s_nxt.wide_f = s_r.wws_s[2];
    rise    = s_nxt.sck_f & ~s_r.sck_f;
    cs_fall = s_r.cs_f & ~s_nxt.cs_f;
    cs_rise = ~s_r.cs_f & s_nxt.cs_f;

    if (s_r.st == S_BUSY) begin
      // array sweep runs on the system clock alone
      if (s_r.op == OP_EXT && !s_r.sweep[8]) begin
        we    = 1'b1;
        waddr = s_r.sweep[7:0];
        if (ext_code(s_r.addr, s_r.wide_f) == EXT_CLEAR) wdata = 16'hffff;
        else wdata = s_r.wide_f ? s_r.data : {s_r.data[7:0], s_r.data[7:0]};
        s_nxt.sweep = s_r.sweep + 9'h001;
      end
      if (s_r.timer == '0) s_nxt.st = S_IDLE;
      else s_nxt.timer = s_r.timer - TW'(1);
    end

    if (rise && s_r.cs_f) begin
      unique case (s_r.st)
        S_IDLE: begin
          if (s_nxt.sdi_f && s_r.stat) begin
            s_nxt.stat = 1'b0;
            s_nxt.ran  = 1'b0;
          end else if (s_nxt.sdi_f) begin
            s_nxt.st   = S_OP;
            s_nxt.cnt  = 5'h00;
            s_nxt.addr = 9'h000;
            s_nxt.data = 16'h0000;
            s_nxt.ran  = 1'b0;
          end
        end
        S_BUSY: begin
          if (s_nxt.sdi_f && s_r.stat) s_nxt.stat = 1'b0;
        end
        S_OP: begin
          s_nxt.op  = {s_r.op[0], s_nxt.sdi_f};
          s_nxt.cnt = s_r.cnt + 5'h01;
          if (s_r.cnt == 5'h01) begin
            s_nxt.st  = S_ADDR;
            s_nxt.cnt = 5'h00;
          end
        end
        S_ADDR: begin
          s_nxt.addr = {s_r.addr[7:0], s_nxt.sdi_f};
          s_nxt.cnt  = s_r.cnt + 5'h01;
          if (s_r.cnt == al - 5'h01) begin
            s_nxt.cnt = 5'h00;
            s_nxt.st  = S_DONE;
            unique case (s_r.op)
              OP_READ: begin
                s_nxt.st    = S_READ;
                s_nxt.out   = 1'b0;
                s_nxt.drive = 1'b1;
              end
              OP_WRITE: s_nxt.st = S_DATA;
              OP_ERASE: s_nxt.pend = s_r.unlock;
              OP_EXT: begin
                unique case (ext_code(s_nxt.addr, s_r.wide_f))
                  EXT_UNLOCK: s_nxt.unlock = 1'b1;
                  EXT_LOCK:   s_nxt.unlock = 1'b0;
                  EXT_CLEAR:  s_nxt.pend = s_r.unlock;
                  EXT_FILL:   s_nxt.st = S_DATA;
                endcase
              end
            endcase
          end
        end
        S_DATA: begin
          s_nxt.data = {s_r.data[14:0], s_nxt.sdi_f};
          s_nxt.cnt  = s_r.cnt + 5'h01;
          if (s_r.cnt == dl - 5'h01) begin
            s_nxt.st   = S_DONE;
            s_nxt.pend = s_r.unlock;
          end
        end
        S_READ: begin
          // first bit of each word comes straight from the array
          if (s_r.cnt == 5'h00) begin
            val = s_r.wide_f ? rd : {(s_r.addr[0] ? rd[15:8] : rd[7:0]), 8'h00};
            s_nxt.out = val[15];
            s_nxt.sh  = {val[14:0], 1'b0};
          end else begin
            s_nxt.out = s_r.sh[15];
            s_nxt.sh  = {s_r.sh[14:0], 1'b0};
          end
          s_nxt.cnt = s_r.cnt + 5'h01;
          if (s_r.cnt == dl - 5'h01) begin
            s_nxt.cnt  = 5'h00;
            s_nxt.addr = s_r.wide_f ? {1'b0, s_r.addr[7:0] + 8'h01}
                                    : s_r.addr + 9'h001;
          end
        end
        S_DONE: begin
        end
      endcase
    end

    if (cs_rise && (s_r.st == S_BUSY || s_r.ran)) s_nxt.stat = 1'b1;
    if (cs_fall) s_nxt.stat = 1'b0;
    if (cs_fall && s_r.st != S_BUSY) begin
      s_nxt.pend = 1'b0;
      s_nxt.st   = S_IDLE;
      if (s_r.pend) begin
        s_nxt.st    = S_BUSY;
        s_nxt.timer = TW'(PROG_CYCLES - 1);
        s_nxt.sweep = 9'h000;
        s_nxt.ran   = 1'b1;
        if (s_r.op != OP_EXT) begin
          // merge replaces the word outright, so no prior erase is needed
          val   = (s_r.op == OP_ERASE) ? 16'hffff : s_r.data;
          we    = 1'b1;
          waddr = widx;
          if (s_r.wide_f) wdata = val;
          else if (s_r.addr[0]) wdata = {val[7:0], rd[7:0]};
          else wdata = {rd[15:8], val[7:0]};
        end
      end
    end else if (!s_nxt.cs_f && s_r.st != S_BUSY) begin
      s_nxt.st   = S_IDLE;
      s_nxt.pend = 1'b0;
    end

    if (s_nxt.stat) begin
      s_nxt.drive = 1'b1;
      s_nxt.out   = (s_nxt.st != S_BUSY);
    end else if (s_nxt.st != S_READ) begin
      s_nxt.drive = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) s_r <= '0;
    else s_r <= s_nxt;
  end

  // array has no reset; content survives like nonvolatile cells
  always_ff @(posedge clk) begin
    if (we) mem[waddr] <= wdata;
  end

  assign pins.do_o      = s_r.out;
  assign pins.do_oe_n   = ~s_r.drive;
  assign prog_busy      = (s_r.st == S_BUSY);
  assign prog_unlocked  = s_r.unlock;

endmodule : eeprom_device

// *** hw/eeprom_host.sv ***
// host controller end: frames commands, reads bursts, polls ready status
// assumes the device answers on the shared data-out wire of the pin bundle
`timescale 1ns/1ps
module eeprom_host
  import eeprom_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  eeprom_if.host           pins,
  input  wire logic        wide,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire cmd_t        cmd,
  input  wire logic [8:0]  cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic [8:0]  read_words,
  output logic [15:0]      rdata,
  output logic             rdata_valid,
  output logic             done
);

  typedef enum logic [2:0] {
    H_IDLE, H_SHIFT, H_READ, H_GAP, H_SETTLE, H_POLL, H_REL
  } host_state_t;

  typedef struct packed {
    logic [2:0]  do_s;
    logic        do_f;
    host_state_t st;
    logic [7:0]  ph;
    logic        cs;
    logic        sck;
    logic        sdi;
    logic        wide_q;
    logic [27:0] fr;
    logic [4:0]  nb;
    logic [15:0] word;
    logic [4:0]  bits;
    logic [8:0]  left;
    logic        prog;
    logic [15:0] rdata;
    logic        rvalid;
    logic        done;
  } host_t;

  host_t      h_r;
  host_t      h_nxt;
  logic       tick;
  logic [1:0] op;
  logic [1:0] code;
  logic       ext;
  logic       has_data;

  always_comb begin
    h_nxt        = h_r;
    h_nxt.rvalid = 1'b0;
    h_nxt.done   = 1'b0;
    h_nxt.do_s   = {h_r.do_s[1:0], pins.sdo};
    if (h_r.do_s[1] == h_r.do_s[2]) h_nxt.do_f = h_r.do_s[2];
    tick = (h_r.ph == 8'h00);
    if (h_r.st != H_IDLE && h_r.st != H_POLL) begin
      h_nxt.ph = tick ? 8'(SCK_HALF_CYC - 1) : h_r.ph - 8'h01;
    end
    unique case (cmd)
      CMD_READ:  op = OP_READ;
      CMD_WRITE: op = OP_WRITE;
      CMD_ERASE: op = OP_ERASE;
      default:   op = OP_EXT;
    endcase
    unique case (cmd)
      CMD_UNLOCK: code = EXT_UNLOCK;
      CMD_CLEAR:  code = EXT_CLEAR;
      CMD_FILL:   code = EXT_FILL;
      default:    code = EXT_LOCK;
    endcase
    ext      = (op == OP_EXT);
    has_data = (cmd == CMD_WRITE || cmd == CMD_FILL);

    unique case (h_r.st)
      H_IDLE: begin
        if (cmd_valid) begin
          h_nxt.st     = H_SHIFT;
          h_nxt.wide_q = wide;
          h_nxt.cs     = 1'b1;
          h_nxt.sdi    = 1'b1;
          h_nxt.ph     = 8'(SCK_HALF_CYC - 1);
          h_nxt.prog   = has_data || cmd == CMD_ERASE || cmd == CMD_CLEAR;
          h_nxt.left   = (read_words == 9'h000) ? 9'h001 : read_words;
          h_nxt.bits   = 5'h00;
          h_nxt.nb     = 5'h03 + addr_len(wide) + (has_data ? data_len(wide) : 5'h00);
          if (wide) h_nxt.fr = {1'b1, op, (ext ? {code, 6'h00} : cmd_addr[7:0]),
                                cmd_wdata, 1'b0};
          else h_nxt.fr = {1'b1, op, (ext ? {code, 7'h00} : cmd_addr), cmd_wdata[7:0], 8'h00};
        end
      end
      H_SHIFT: begin
        if (tick && !h_r.sck) h_nxt.sck = 1'b1;
        else if (tick) begin
          h_nxt.sck = 1'b0;
          h_nxt.nb  = h_r.nb - 5'h01;
          h_nxt.fr  = {h_r.fr[26:0], 1'b0};
          h_nxt.sdi = h_r.fr[26];
          if (h_r.nb == 5'h01) begin
            h_nxt.sdi = 1'b0;
            if (op == OP_READ)
              h_nxt.st = H_READ;
            else begin
              h_nxt.st = H_GAP;
              h_nxt.cs = 1'b0;
              h_nxt.ph = 8'(MIN_DESELECT_CYC - 1);
            end
          end
        end
      end
      H_READ: begin
        // sampled half a period after the rise that moved the output
        if (tick && !h_r.sck) h_nxt.sck = 1'b1;
        else if (tick) begin
          h_nxt.sck  = 1'b0;
          h_nxt.word = {h_r.word[14:0], h_r.do_f};
          h_nxt.bits = h_r.bits + 5'h01;
          if (h_r.bits == data_len(h_r.wide_q) - 5'h01) begin
            h_nxt.bits   = 5'h00;
            h_nxt.rvalid = 1'b1;
            h_nxt.rdata  = h_r.wide_q ? h_nxt.word : {8'h00, h_nxt.word[7:0]};
            h_nxt.left   = h_r.left - 9'h001;
            if (h_r.left == 9'h001) begin
              h_nxt.st = H_GAP;
              h_nxt.cs = 1'b0;
              h_nxt.ph = 8'(MIN_DESELECT_CYC - 1);
            end
          end
        end
      end
      H_GAP: begin
        if (tick && h_r.prog) begin
          h_nxt.st = H_SETTLE;
          h_nxt.cs = 1'b1;
        end else if (tick) begin
          h_nxt.st   = H_IDLE;
          h_nxt.done = 1'b1;
        end
      end
      H_SETTLE: begin
        // lets the device take the wire before ready is trusted
        if (tick) h_nxt.st = H_POLL;
      end
      H_POLL: begin
        if (h_r.do_f) begin
          h_nxt.st  = H_REL;
          h_nxt.sdi = 1'b1;
          h_nxt.ph  = 8'(SCK_HALF_CYC - 1);
        end
      end
      H_REL: begin
        if (tick && !h_r.sck) h_nxt.sck = 1'b1;
        else if (tick) begin
          h_nxt.sck  = 1'b0;
          h_nxt.sdi  = 1'b0;
          h_nxt.cs   = 1'b0;
          h_nxt.prog = 1'b0;
          h_nxt.st   = H_GAP;
          h_nxt.ph   = 8'(MIN_DESELECT_CYC - 1);
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) h_r <= '0;
    else h_r <= h_nxt;
  end

  assign cmd_ready   = (h_r.st == H_IDLE);
  assign pins.cs     = h_r.cs;
  assign pins.sck    = h_r.sck;
  assign pins.sdi    = h_r.sdi;
  assign pins.wws    = wide;
  assign rdata       = h_r.rdata;
  assign rdata_valid = h_r.rvalid;
  assign done        = h_r.done;

endmodule : eeprom_host

// *** hw/eeprom_if.sv ***
// pin bundle between the host controller and the serial eeprom
// the data-out wire idles high when released, like a pulled-up pin
`timescale 1ns/1ps
interface eeprom_if;
  logic cs;
  logic sck;
  logic sdi;
  logic wws;
  logic do_o;
  logic do_oe_n;
  logic sdo;

  assign sdo = do_oe_n ? 1'b1 : do_o;

  modport dev (input cs, input sck, input sdi, input wws, output do_o, output do_oe_n);
  modport host (output cs, output sck, output sdi, output wws, input sdo);
endinterface : eeprom_if

// *** hw/eeprom_pkg.sv ***
// shared constants, opcodes and host command codes for the serial eeprom link
// assumes a 200 MHz system clock on both ends
package eeprom_pkg;

  localparam int CLK_PERIOD_NS    = 5;
  localparam int SCK_HALF_NS      = 250;
  localparam int SCK_HALF_CYC     = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_DESELECT_NS  = 250;
  localparam int MIN_DESELECT_CYC = (MIN_DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_TIME_MS     = 5;
  localparam int PROG_CYC         = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;

  localparam int WORDS         = 256;
  localparam int ADDR_BITS_X16 = 8;
  localparam int ADDR_BITS_X8  = 9;
  localparam int DATA_BITS_X16 = 16;
  localparam int DATA_BITS_X8  = 8;

  localparam logic [1:0] OP_EXT   = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;

  localparam logic [1:0] EXT_LOCK   = 2'h0;
  localparam logic [1:0] EXT_FILL   = 2'h1;
  localparam logic [1:0] EXT_CLEAR  = 2'h2;
  localparam logic [1:0] EXT_UNLOCK = 2'h3;

  typedef enum logic [2:0] {
    CMD_READ, CMD_WRITE, CMD_ERASE, CMD_UNLOCK, CMD_LOCK, CMD_CLEAR, CMD_FILL
  } cmd_t;

  function automatic logic [4:0] addr_len(input logic wide);
    return wide ? 5'(ADDR_BITS_X16) : 5'(ADDR_BITS_X8);
  endfunction : addr_len

  function automatic logic [4:0] data_len(input logic wide);
    return wide ? 5'(DATA_BITS_X16) : 5'(DATA_BITS_X8);
  endfunction : data_len

endpackage : eeprom_pkg

// *** verif/eeprom_link_sva.sv ***
// assertions on the pin bundle between the host and the eeprom device
// assumes one clock domain, synchronous active-high reset, small PROG_CYCLES
`timescale 1ns/1ps
module eeprom_link_sva #(
  parameter int PROG_CYCLES = 300
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs,
  input wire logic sck,
  input wire logic sdi,
  input wire logic do_o,
  input wire logic do_oe_n,
  input wire logic prog_busy,
  input wire logic prog_unlocked
);
  logic [4:0]  since_cs_r;
  logic [3:0]  cs_low_r;
  logic        status_r;
  logic [19:0] busy_len_r;

  // status is told from read data by how soon the wire is driven after select
  always_ff @(posedge clk) begin
    if (reset) begin
      since_cs_r <= '0;
      cs_low_r   <= '0;
      status_r   <= 1'b0;
      busy_len_r <= '0;
    end else begin
      since_cs_r <= !cs ? 5'h00 : (since_cs_r == 5'h1f ? since_cs_r : since_cs_r + 5'h01);
      cs_low_r   <= cs ? 4'h0 : (cs_low_r == 4'hf ? cs_low_r : cs_low_r + 4'h1);
      status_r   <= !cs ? 1'b0 : (status_r || (!do_oe_n && since_cs_r < 5'h10));
      busy_len_r <= prog_busy ? busy_len_r + 20'h0_0001 : 20'h0_0000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence busy_shown;
    !do_oe_n && !do_o;
  endsequence
  sequence ready_shown;
    !do_oe_n && do_o;
  endsequence
  sequence released;
    do_oe_n;
  endsequence

  chk_deselect_release: assert property ($fell(cs) |-> ##[1:8] released)
    else $error("data wire still driven after deselect");
  chk_read_stable: assert property ($fell(sck) && cs && !do_oe_n |-> do_o == $past(do_o, 20))
    else $error("read bit moved away from the clock rise");
  chk_dummy_zero: assert property ($fell(do_oe_n) && since_cs_r > 5'h10 |-> (!do_o)[*8])
    else $error("read did not lead with a zero bit");
  chk_status_release: assert property (
    status_r && !do_oe_n && sdi && $rose(sck) |-> ##[1:8] released)
    else $error("status not released by a clocked one");
  chk_busy_status: assert property (prog_busy && $rose(cs) |-> ##[1:8] busy_shown)
    else $error("busy not shown on select");
  chk_ready_status: assert property (
    $fell(prog_busy) && cs && !do_oe_n |-> ##[1:8] ready_shown)
    else $error("ready not shown at end of cycle");
  chk_cycle_start: assert property ($rose(prog_busy) |-> !cs && cs_low_r < 4'ha)
    else $error("program cycle not started by deselect");
  chk_cycle_length: assert property ($fell(prog_busy) |->
    busy_len_r >= PROG_CYCLES - 1 && busy_len_r <= PROG_CYCLES + 1)
    else $error("program cycle length wrong");
  chk_start_unlocked: assert property ($rose(prog_busy) |-> prog_unlocked)
    else $error("program cycle started while locked");
  chk_lock_in_frame: assert property ($changed(prog_unlocked) |-> cs)
    else $error("lock state changed outside a frame");
endmodule : eeprom_link_sva

// *** verif/tb.sv ***
// self-checking bench: host and device joined by the pin bundle
// assumes a 200 MHz clock and a shortened self-timed cycle
`timescale 1ns/1ps
module tb;
  import eeprom_pkg::*;
  localparam int PROG_SMALL = 300;
  logic        clk;
  logic        reset;
  logic        wide;
  logic        cmd_valid;
  logic        cmd_ready;
  cmd_t        cmd;
  logic [8:0]  cmd_addr;
  logic [8:0]  read_words;
  logic [15:0] cmd_wdata;
  logic [15:0] rdata;
  logic        rdata_valid;
  logic        done;
  logic        prog_busy;
  logic        prog_unlocked;
  logic        busy_seen;
  logic        sck_q;
  logic        cs_q;
  logic [26:0] shift_sr;
  logic [26:0] frame_sr;
  int          rises;
  int          frame_bits;
  int          mismatches;
  int          check_count;
  logic [15:0] got[$];
  logic [15:0] exp_q[$];

  eeprom_if bus ();
  eeprom_device #(.PROG_CYCLES(PROG_SMALL)) eeprom_device_i (
    .clk(clk), .reset(reset), .pins(bus), .prog_busy(prog_busy),
    .prog_unlocked(prog_unlocked));
  eeprom_host eeprom_host_i (
    .clk(clk), .reset(reset), .pins(bus), .wide(wide), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .read_words(read_words), .rdata(rdata), .rdata_valid(rdata_valid), .done(done));
  eeprom_link_sva #(.PROG_CYCLES(PROG_SMALL)) eeprom_link_sva_i (
    .clk(clk), .reset(reset), .cs(bus.cs), .sck(bus.sck), .sdi(bus.sdi), .do_o(bus.do_o),
    .do_oe_n(bus.do_oe_n), .prog_busy(prog_busy), .prog_unlocked(prog_unlocked));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // wire watcher: counts clock rises per frame and keeps the shifted bits
  always @(negedge clk) begin
    if (prog_busy === 1'b1) busy_seen = 1'b1;
    if (rdata_valid === 1'b1) got.push_back(rdata);
    if (bus.cs === 1'b1 && bus.sck === 1'b1 && sck_q === 1'b0) begin
      rises++;
      shift_sr = {shift_sr[25:0], bus.sdi};
    end
    // polling frames carry one rise at most, so they never overwrite
    if (bus.cs === 1'b0 && cs_q === 1'b1 && rises > 1) begin
      frame_bits = rises;
      frame_sr   = shift_sr;
    end
    if (bus.cs !== 1'b1) begin
      rises    = 0;
      shift_sr = '0;
    end
    sck_q = bus.sck;
    cs_q  = bus.cs;
  end

  task automatic check_word(input logic [15:0] got_v, input logic [15:0] exp_v);
    check_count++;
    if (got_v !== exp_v) begin
      mismatches++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got_v, exp_v);
    end
  endtask : check_word

  task automatic check_bit(input logic got_v, input logic exp_v);
    check_count++;
    if (got_v !== exp_v) begin
      mismatches++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got_v, exp_v);
    end
  endtask : check_bit

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // one command through the host port; cmd stays put until done
  task automatic run(input cmd_t c, input logic [8:0] a, input logic [15:0] d,
                     input logic [8:0] n);
    int k;
    k = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (k >= 100) begin
      mismatches++;
      $display("unexpected at %0t: host never ready", $time);
    end
    @(posedge clk);
    cmd        <= c;
    cmd_addr   <= a;
    cmd_wdata  <= d;
    read_words <= n;
    cmd_valid  <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    k = 0;
    @(negedge clk);
    while (done !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 20000) begin
      mismatches++;
      $display("unexpected at %0t: command never finished", $time);
    end
  endtask : run

  task automatic read_check(input logic [8:0] a, input logic [8:0] n);
    got.delete();
    run(CMD_READ, a, 16'h0000, n);
    check_word(16'(got.size()), 16'(n));
    for (int i = 0; i < exp_q.size() && i < got.size(); i++) begin
      check_word(got[i], exp_q[i]);
    end
  endtask : read_check

  initial begin
    #(80000 * CLK_PERIOD_NS);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    reset = 1'b1;
    wide = 1'b1;
    cmd_valid = 1'b0;
    cmd = CMD_READ;
    cmd_addr = '0;
    cmd_wdata = '0;
    read_words = 9'h001;
    busy_seen = 1'b0;
    sck_q = 1'b0;
    cs_q = 1'b0;
    shift_sr = '0;
    frame_sr = '0;
    rises = 0;
    frame_bits = 0;
    mismatches = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    run(CMD_WRITE, 9'h005, 16'h0f0f, 9'h001);
    check_bit(busy_seen, 1'b0);
    check_bit(prog_unlocked, 1'b0);
    $display("test locked_write done");
    run(CMD_UNLOCK, 9'h0c0, 16'h0000, 9'h001);
    check_bit(prog_unlocked, 1'b1);
    check_word(16'(frame_bits), 16'h000b);
    check_word(16'(frame_sr[10:6]), 16'h0013);
    busy_seen = 1'b0;
    run(CMD_FILL, 9'h040, 16'ha5c3, 9'h001);
    check_bit(busy_seen, 1'b1);
    exp_q = '{16'ha5c3, 16'ha5c3};
    read_check(9'h0ff, 9'h002);
    $display("test fill_and_wrap done");
    run(CMD_WRITE, 9'h000, 16'h1234, 9'h001);
    check_word(16'(frame_bits), 16'h001b);
    check_word(frame_sr[15:0], 16'h1234);
    check_word(16'(frame_sr[26:16]), 16'h0500);
    run(CMD_ERASE, 9'h001, 16'h0000, 9'h001);
    exp_q = '{16'ha5c3, 16'h1234, 16'hffff};
    read_check(9'h0ff, 9'h003);
    $display("test write_erase done");
    run(CMD_LOCK, 9'h000, 16'h0000, 9'h001);
    check_bit(prog_unlocked, 1'b0);
    busy_seen = 1'b0;
    run(CMD_WRITE, 9'h000, 16'h0000, 9'h001);
    check_bit(busy_seen, 1'b0);
    exp_q = '{16'h1234};
    read_check(9'h000, 9'h001);
    $display("test relock done");
    run(CMD_UNLOCK, 9'h0c0, 16'h0000, 9'h001);
    run(CMD_CLEAR, 9'h080, 16'h0000, 9'h001);
    exp_q = '{16'hffff, 16'hffff};
    read_check(9'h000, 9'h002);
    $display("test clear_all done");
    // byte mode: odd byte address is the high half of its word
    @(posedge clk);
    wide <= 1'b0;
    run(CMD_WRITE, 9'h003, 16'h005a, 9'h001);
    check_word(16'(frame_bits), 16'h0014);
    exp_q = '{16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h005a};
    read_check(9'h1ff, 9'h005);
    $display("test byte_mode done");
    tally_and_finish();
  end
endmodule : tb
